// [common/sdiar_pkg.sv]
// Purpose: Shared constants and types for the embedded-audio router
// Assumes: 32-bit AHB-Lite registers, 24-bit audio words
// Notes: Offsets are byte addresses inside the block window
package sdiar_pkg;
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_SRCSEL = 8'h04;
  localparam logic [7:0] A_BYPASS = 8'h08;
  localparam logic [7:0] A_VDELAY = 8'h0c;
  localparam logic [7:0] A_ROUTE = 8'h10;
  localparam logic [7:0] A_GAIN = 8'h20;
  localparam logic [7:0] A_SDELAY = 8'h30;
  localparam logic [7:0] A_TONE = 8'h38;
  localparam logic [7:0] A_STATUS = 8'h3c;
  localparam logic [7:0] A_GPI = 8'h40;
  localparam int F_AUTO = 0;
  localparam int F_MMUTE = 1;
  localparam int F_GEN = 4;
  localparam int F_PMUTE = 8;
  localparam int F_GPO = 16;
  localparam int F_GPIIN = 20;
  localparam int F_ARC = 24;
  localparam logic [3:0] GEN_RST = 4'hf;
  localparam logic [7:0] GAIN_UNITY = 8'h80;
  localparam logic [3:0] GPI_IDLE = 4'hf;
  localparam logic [4:0] SRC_TONE = 5'h10;
  localparam logic [4:0] SRC_MUTE = 5'h14;
  localparam logic [4:0] SRC_RP155 = 5'h15;
  localparam logic [4:0] SRC_R68 = 5'h16;
  localparam logic [23:0] AMP_RP155 = 24'h0ccccd;
  localparam logic [23:0] AMP_R68 = 24'h101d2b;
  typedef enum logic [0:0] {SEQ_IDLE = 1'b0, SEQ_RUN = 1'b1} sdiar_seq_e;
  typedef struct packed {
    logic valid;
    logic [3:0] slot;
    logic [23:0] data;
    logic nonPcm;
    logic err;
  } sdiar_in_s;
  typedef struct packed {
    logic valid;
    logic [1:0] group;
    logic [1:0] chan;
    logic [23:0] data;
    logic srcBypass;
  } sdiar_out_s;
  typedef struct packed {
    logic [7:0] aAddr;
    logic aSel;
    logic aWr;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic autoMode;
    logic masterMute;
    logic [3:0] grpEn;
    logic [7:0] pairMute;
    logic [7:0][2:0] srcSel;
    logic [7:0][1:0] bypass;
    logic [3:0] vDelay;
    logic [15:0][4:0] route;
    logic [15:0][7:0] gain;
    logic [15:0][3:0] sDelay;
    logic [3:0][7:0] toneLvl;
    logic [3:0] trigRise;
    logic [3:0][2:0] action;
    logic [1:0] gpo;
    logic [3:0] gpiLast;
    logic [2:0] arcPreset;
    logic [7:0] seenPair;
    logic [7:0] pairPresent;
    logic [3:0] seenErr;
    logic [3:0] grpErr;
    logic [15:0] nonPcm;
    logic [15:0][15:0][23:0] hist;
    sdiar_seq_e seq;
    logic [3:0] idx;
    logic [5:0] phase;
    sdiar_out_s out;
  } sdiar_state_s;
endpackage

// [verilog/sdiar_router.sv]
// Purpose: Embedded-audio de-embed status, routing, processing and re-embed
// Assumes: Samples arrive synchronous to ref_clk; outTick marks one
//   output sample period aligned to the delayed output video
// Notes: Reads take one wait state, writes none; all outputs registered
// Functional notes
// [R01] Four input groups are taken in, four output groups are emitted.
// [R02] Up to eight channel pairs are routed to the output stream.
// [R03] Eight selectors pick input pairs; defaults walk group 1 pairs upward.
// [R04] Each output group has its own embed enable.
// [R05] Each output channel picks a routed source; defaults give source n A/B. Code: group n channels 3/4 default to source n+4 A/B.
// [R06] Sources include four level-set tones, mute and two reference tones.
// [R07] Gain and delay are set separately per side of each channel.
// [R08] Channel status bit 1 marks non-PCM; converter is then bypassed.
// [R09] Manual mode applies bypass only from per-source settings.
// [R10] Auto mode bypasses the converter per side carrying non-PCM data.
// [R11] Master mute silences every pair on top of per-pair mutes.
// [R12] A side whose source has no incoming audio is muted.
// [R13] Read-only presence flag per input group.
// [R14] Read-only error flag per input group.
// [R15] Read-only presence flag per channel pair.
// [R16] Read-only PCM or data type per channel pair.
// [R17] Four automation inputs and two automation outputs.
// [R18] Automation events act in trigger order, newer ones override.
// [R19] Each input has a rising or falling trigger and an action.
// [R20] Audio is delayed by the video processing delay before re-embed.
// [R21] Presence flags clear when a field passes with no audio.
//
// Chosen here: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module sdiar_router (
  input wire logic ref_clk, // 20 MHz clock
  input wire logic rstn, // Synchronous reset, active low
  input wire logic ce, // Clock enable, freezes all state when low
  input wire logic hsel, // AHB slave select
  input wire logic [31:0] haddr, // AHB address
  input wire logic [1:0] htrans, // AHB transfer type
  input wire logic hwrite, // AHB write
  input wire logic [2:0] hsize, // AHB size, word only
  input wire logic [31:0] hwdata, // AHB write data
  input wire logic hready, // AHB bus ready
  output logic [31:0] hrdata, // AHB read data
  output logic hreadyout, // AHB slave ready
  output logic hresp, // AHB response, always OKAY
  input wire sdiar_pkg::sdiar_in_s inSmp, // De-embedded sample
  input wire logic inField, // Input video field start
  input wire logic outTick, // Output sample period start
  output var sdiar_pkg::sdiar_out_s outSmp, // Sample to embedder
  input wire logic [3:0] gpiIn, // Automation inputs, idle high
  output logic [1:0] gpo, // Automation outputs
  output logic [2:0] arcPreset // Aspect-ratio preset from automation
);
  sdiar_pkg::sdiar_state_s st;
  sdiar_pkg::sdiar_state_s nx;

  function automatic sdiar_pkg::sdiar_state_s rstState();
    sdiar_pkg::sdiar_state_s r;
    r = '0;
    r.hreadyout = 1'b1;
    r.grpEn = sdiar_pkg::GEN_RST;
    r.gpiLast = sdiar_pkg::GPI_IDLE;
    // Selector i starts on input pair i, walking groups upward
    for (int i = 0; i < 8; i++)
    begin
      r.srcSel[i] = 3'(i); // [R03]
    end
    for (int k = 0; k < 16; k++)
    begin
      // Channels 3/4 of group n default to source n+4
      r.route[k] = {1'b0, 3'(k / 4 + (k % 4 / 2) * 4), 1'(k % 2)}; // [R05]
      r.gain[k] = sdiar_pkg::GAIN_UNITY;
    end
    return r;
  endfunction

  function automatic logic [23:0] satGain(input logic [23:0] s,
                                          input logic [7:0] g);
    logic signed [33:0] p;
    p = $signed({{10{s[23]}}, s}) * $signed({26'h0, g});
    p = p >>> 7;
    // 0x80 is unity; results clip rather than wrap into the other sign
    if (p > 34'sh7fffff)
      return 24'h7fffff;
    else if (p < -34'sh800000)
      return 24'h800000;
    else
      return p[23:0];
  endfunction

  function automatic logic [3:0] dlySum(input logic [3:0] a,
                                        input logic [3:0] b);
    logic [4:0] s;
    s = {1'b0, a} + {1'b0, b};
    // Saturate: a wrapped sum would give a much shorter delay
    return s[4] ? 4'hf : s[3:0];
  endfunction

  // Banks of four words: route and gain, decoded alike on read and write
  function automatic logic inBank(input logic [7:0] a,
                                  input logic [7:0] base);
    return a[7:4] == base[7:4] && a[1:0] == 2'h0;
  endfunction

  // Reference tones have fixed levels; custom tones follow their level byte
  function automatic logic [23:0] toneAmp(input logic [4:0] sel,
                                          input logic [3:0][7:0] lvl);
    logic [23:0] a;
    a = '0;
    if (sel == sdiar_pkg::SRC_RP155)
      a = sdiar_pkg::AMP_RP155; // [R06]
    else if (sel == sdiar_pkg::SRC_R68)
      a = sdiar_pkg::AMP_R68; // [R06]
    else if (sel < sdiar_pkg::SRC_MUTE)
      a = {1'b0, lvl[sel[1:0]], 15'h0}; // [R06]
    return a;
  endfunction

  function automatic logic [31:0] rdReg(input sdiar_pkg::sdiar_state_s s,
                                        input logic [3:0] gpiNow);
    logic [31:0] d;
    logic [7:0] typ;
    d = '0;
    for (int p = 0; p < 8; p++)
    begin
      // A pair reads as data when either side carries non-PCM
      typ[p] = s.nonPcm[2 * p] | s.nonPcm[2 * p + 1];
    end
    if (s.aAddr == sdiar_pkg::A_CTRL)
    begin
      d[sdiar_pkg::F_AUTO] = s.autoMode;
      d[sdiar_pkg::F_MMUTE] = s.masterMute;
      d[sdiar_pkg::F_GEN +: 4] = s.grpEn;
      d[sdiar_pkg::F_PMUTE +: 8] = s.pairMute;
    end
    else if (s.aAddr == sdiar_pkg::A_SRCSEL)
      d[23:0] = s.srcSel;
    else if (s.aAddr == sdiar_pkg::A_BYPASS)
      d[15:0] = s.bypass;
    else if (s.aAddr == sdiar_pkg::A_VDELAY)
      d[3:0] = s.vDelay;
    else if (inBank(s.aAddr, sdiar_pkg::A_ROUTE))
    begin
      for (int i = 0; i < 4; i++)
      begin
        d[8 * i +: 5] = s.route[{s.aAddr[3:2], 2'(i)}];
      end
    end
    else if (inBank(s.aAddr, sdiar_pkg::A_GAIN))
      d = s.gain[{s.aAddr[3:2], 2'h0} +: 4];
    else if (s.aAddr == sdiar_pkg::A_SDELAY)
      d = s.sDelay[7:0];
    else if (s.aAddr == sdiar_pkg::A_SDELAY + 8'h04)
      d = s.sDelay[15:8];
    else if (s.aAddr == sdiar_pkg::A_TONE)
      d = s.toneLvl;
    else if (s.aAddr == sdiar_pkg::A_STATUS)
    begin
      for (int g = 0; g < 4; g++)
      begin
        d[g] = |s.pairPresent[2 * g +: 2]; // [R13]
      end
      d[7:4] = s.grpErr; // [R14]
      d[15:8] = s.pairPresent; // [R15]
      d[23:16] = typ; // [R16]
    end
    else if (s.aAddr == sdiar_pkg::A_GPI)
    begin
      d[3:0] = s.trigRise;
      d[15:4] = s.action;
      d[sdiar_pkg::F_GPO +: 2] = s.gpo;
      d[sdiar_pkg::F_GPIIN +: 4] = gpiNow;
      d[sdiar_pkg::F_ARC +: 3] = s.arcPreset;
    end
    return d;
  endfunction

  always_comb
  begin
    logic [31:0] w;
    logic [3:0] rise;
    logic [3:0] fall;
    logic [7:0] curPair;
    logic [3:0] curErr;
    logic [4:0] sel;
    logic [3:0] side;
    logic [2:0] pair;
    logic [3:0] slot;
    logic [23:0] raw;
    logic [23:0] amp;
    logic [23:0] smp;
    logic cvByp;
    logic gnByp;
    logic mute;
    w = hwdata;
    rise = '0;
    fall = '0;
    curPair = '0;
    curErr = '0;
    sel = '0;
    side = '0;
    pair = '0;
    slot = '0;
    raw = '0;
    amp = '0;
    smp = '0;
    cvByp = 1'b0;
    gnByp = 1'b0;
    mute = 1'b0;
    nx = st;
    nx.hresp = 1'b0;

    // Reads take one wait state so a read right after a write sees it
    if (st.aSel && st.aWr)
    begin
      if (st.aAddr == sdiar_pkg::A_CTRL)
      begin
        nx.autoMode = w[sdiar_pkg::F_AUTO];
        nx.masterMute = w[sdiar_pkg::F_MMUTE];
        nx.grpEn = w[sdiar_pkg::F_GEN +: 4];
        nx.pairMute = w[sdiar_pkg::F_PMUTE +: 8];
      end
      else if (st.aAddr == sdiar_pkg::A_SRCSEL)
        nx.srcSel = w[23:0];
      else if (st.aAddr == sdiar_pkg::A_BYPASS)
        nx.bypass = w[15:0];
      else if (st.aAddr == sdiar_pkg::A_VDELAY)
        nx.vDelay = w[3:0];
      else if (inBank(st.aAddr, sdiar_pkg::A_ROUTE))
      begin
        for (int i = 0; i < 4; i++)
        begin
          nx.route[{st.aAddr[3:2], 2'(i)}] = w[8 * i +: 5];
        end
      end
      else if (inBank(st.aAddr, sdiar_pkg::A_GAIN))
        nx.gain[{st.aAddr[3:2], 2'h0} +: 4] = w;
      else if (st.aAddr == sdiar_pkg::A_SDELAY)
        nx.sDelay[7:0] = w;
      else if (st.aAddr == sdiar_pkg::A_SDELAY + 8'h04)
        nx.sDelay[15:8] = w;
      else if (st.aAddr == sdiar_pkg::A_TONE)
        nx.toneLvl = w;
      else if (st.aAddr == sdiar_pkg::A_GPI)
      begin
        nx.trigRise = w[3:0]; // [R19]
        nx.action = w[15:4]; // [R19]
        nx.gpo = w[sdiar_pkg::F_GPO +: 2]; // [R17]
      end
      nx.aSel = 1'b0;
    end
    else if (st.aSel)
    begin
      nx.hrdata = rdReg(st, st.gpiLast);
      nx.hreadyout = 1'b1;
      nx.aSel = 1'b0;
    end
    // hsize is not decoded: every access is taken as a whole word
    if (hsel && htrans[1] && hready && st.hreadyout)
    begin
      nx.aSel = 1'b1;
      nx.aWr = hwrite;
      nx.aAddr = haddr[7:0];
      nx.hreadyout = hwrite;
    end

    // Input side: history per slot, presence and errors per field
    // Sixteen entries per slot bound the total delay to 15 periods
    if (inSmp.valid)
    begin
      nx.hist[inSmp.slot] = {st.hist[inSmp.slot][14:0], inSmp.data}; // [R20]
      nx.nonPcm[inSmp.slot] = inSmp.nonPcm; // [R08]
      curPair[inSmp.slot[3:1]] = 1'b1; // [R01]
      curErr[inSmp.slot[3:2]] = inSmp.err;
    end
    // A sample in the field-start cycle counts for both fields
    if (inField)
    begin
      nx.pairPresent = st.seenPair | curPair; // [R21]
      nx.grpErr = st.seenErr | curErr; // [R14]
      nx.seenPair = curPair;
      nx.seenErr = curErr;
    end
    else
    begin
      nx.seenPair = st.seenPair | curPair;
      nx.seenErr = st.seenErr | curErr;
    end

    // Automation: later inputs in the same cycle count as newer
    // Action code 0 is no action and leaves the preset alone
    rise = gpiIn & ~st.gpiLast;
    fall = ~gpiIn & st.gpiLast;
    nx.gpiLast = gpiIn;
    for (int i = 0; i < 4; i++)
    begin
      if ((st.trigRise[i] ? rise[i] : fall[i]) && st.action[i] != 3'h0)
        nx.arcPreset = st.action[i]; // [R18]
    end

    // Output sequencer: one output channel per cycle, 16 per tick
    // A tick during a run is ignored, so a run always covers 16 channels
    nx.out.valid = 1'b0;
    case (st.seq)
      sdiar_pkg::SEQ_IDLE:
      begin
        if (outTick)
        begin
          nx.seq = sdiar_pkg::SEQ_RUN;
          nx.idx = 4'h0;
          nx.phase = st.phase + 6'h01;
        end
      end
      sdiar_pkg::SEQ_RUN:
      begin
        sel = st.route[st.idx]; // [R05]
        side = sel[3:0];
        pair = st.srcSel[side[3:1]]; // [R03]
        slot = {pair, side[0]};
        raw = st.hist[slot][dlySum(st.vDelay, st.sDelay[side])]; // [R20]
        if (st.autoMode)
        begin
          cvByp = st.nonPcm[slot]; // [R10]
          gnByp = st.nonPcm[slot];
        end
        else
        begin
          cvByp = st.bypass[side[3:1]][0]; // [R09]
          gnByp = st.bypass[side[3:1]][1]; // [R09]
        end
        // Codes below SRC_TONE are input sides; the rest are generated
        if (sel < sdiar_pkg::SRC_TONE)
        begin
          smp = gnByp ? raw : satGain(raw, st.gain[side]); // [R07]
          // Presence is judged per field, so a lost pair mutes a field late
          mute = st.pairMute[side[3:1]] | ~st.pairPresent[pair]; // [R12]
        end
        else
        begin
          amp = toneAmp(sel, st.toneLvl); // [R06]
          // Square tones flip sign every 32 output periods
          smp = st.phase[5] ? 24'(-amp) : amp;
          cvByp = 1'b0;
        end
        if (mute || st.masterMute) // [R11]
          smp = 24'h0;
        nx.out.valid = st.grpEn[st.idx[3:2]]; // [R04]
        nx.out.group = st.idx[3:2]; // [R01]
        nx.out.chan = st.idx[1:0]; // [R02]
        nx.out.data = smp;
        nx.out.srcBypass = cvByp; // [R08]
        nx.idx = st.idx + 4'h1;
        if (st.idx == 4'hf)
          nx.seq = sdiar_pkg::SEQ_IDLE;
      end
      default:
        nx.seq = sdiar_pkg::SEQ_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    // Reset does not wait for ce, so a frozen block can still be cleared
    if (!rstn)
      st <= rstState();
    else if (ce)
      st <= nx;
  end

  assign hrdata = st.hrdata;
  assign hreadyout = st.hreadyout;
  assign hresp = st.hresp;
  assign outSmp = st.out;
  assign gpo = st.gpo;
  assign arcPreset = st.arcPreset;
endmodule
`default_nettype wire

// [verif/sdiar_router_asserts.sv]
// Purpose: Bus, output sequencer and automation checks for the router
// Assumes: Shadow copies of control fields follow completed bus writes
// Notes: Ticks closer than 18 cycles would desynchronise the run counter
`timescale 1ns/1ps
`default_nettype none
module sdiar_router_asserts (
  input wire logic ref_clk, // Clock
  input wire logic rstn, // Reset, active low
  input wire logic ce, // Clock enable
  input wire logic hsel, // Slave select
  input wire logic [31:0] haddr, // Address
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Write
  input wire logic [31:0] hwdata, // Write data
  input wire logic hready, // Bus ready
  input wire logic hreadyout, // Slave ready
  input wire logic hresp, // Response
  input wire logic outTick, // Output period start
  input wire sdiar_pkg::sdiar_out_s outSmp, // Sample to embedder
  input wire logic [3:0] gpiIn, // Automation inputs
  input wire logic [1:0] gpo, // Automation outputs
  input wire logic [2:0] arcPreset // Preset from automation
);
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);
  logic take, fire, wrPend, mMute, trig0;
  logic [7:0] wrAddr;
  logic [3:0] grpEn, gpiPrev;
  logic [1:0] gpoSh;
  logic [2:0] act0;
  logic [4:0] cnt;
  assign take = ce && hsel && htrans[1] && hready && hreadyout;
  // Only lone edges on input 0 are judged, so priority is not modelled
  assign fire = (trig0 ? !gpiPrev[0] && gpiIn[0] : gpiPrev[0] && !gpiIn[0])
    && gpiIn[3:1] == gpiPrev[3:1];
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      {wrPend, mMute, trig0, gpoSh, act0, cnt, wrAddr} <= '0;
      grpEn <= 4'hf;
      gpiPrev <= 4'hf;
    end
    else if (ce)
    begin
      gpiPrev <= gpiIn;
      wrPend <= take && hwrite;
      wrAddr <= haddr[7:0];
      if (outTick && cnt == 5'h0)
        cnt <= 5'h1;
      else if (cnt != 5'h0)
        // Seventeen counts: the first sample shows two edges after the tick
        cnt <= (cnt == 5'h11) ? 5'h0 : cnt + 5'h1;
      if (wrPend && wrAddr == sdiar_pkg::A_CTRL)
      begin
        mMute <= hwdata[sdiar_pkg::F_MMUTE];
        grpEn <= hwdata[7:4];
      end
      if (wrPend && wrAddr == sdiar_pkg::A_GPI)
      begin
        {gpoSh, trig0, act0} <= {hwdata[17:16], hwdata[0], hwdata[6:4]};
      end
    end
  end
  sequence rdWait;
    !hreadyout ##1 hreadyout;
  endsequence
  sequence halfRun;
    outSmp.valid [*8];
  endsequence
  a_write_nowait: assert property (take && hwrite |=> hreadyout)
    else $error("write data phase stalled");
  a_read_onewait: assert property (take && !hwrite |=> rdWait)
    else $error("read wait not one cycle");
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("response not okay");
  a_run_index: assert property (
    outSmp.valid |-> cnt != 5'h0
      && {outSmp.group, outSmp.chan} == 4'(cnt - 5'h2))
    else $error("output index out of step");
  a_run_length: assert property (
    outTick && cnt == 5'h0 && grpEn == 4'hf
      |=> ##1 halfRun ##1 halfRun ##1 !outSmp.valid)
    else $error("output run not sixteen samples");
  a_group_enable: assert property (
    outSmp.valid |-> grpEn[outSmp.group])
    else $error("disabled group embedded");
  a_master_mute: assert property (
    outSmp.valid && mMute |-> outSmp.data == 24'h0)
    else $error("muted sample not silent");
  a_gpo_follows: assert property (
    !$stable(gpoSh) |-> ##[0:1] gpo == gpoSh)
    else $error("output pins ignore register");
  a_trigger_action: assert property (
    fire && act0 != 3'h0 |-> ##[1:3] arcPreset == act0)
    else $error("trigger action not applied");
endmodule
bind sdiar_router sdiar_router_asserts u_chk (.ref_clk(ref_clk), .rstn(rstn),
  .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .outTick(outTick), .outSmp(outSmp), .gpiIn(gpiIn), .gpo(gpo),
  .arcPreset(arcPreset));
`default_nettype wire

// [verif/sdiar_far_end.sv]
// Purpose: Upstream de-embedder and downstream embedder stand-in
// Assumes: Ticks are at least 20 cycles apart
// Notes: Released sample data shows inverted bits, never the old word
`timescale 1ns/1ps
`default_nettype none
module sdiar_far_end (
  input wire logic ref_clk, // Clock
  output var sdiar_pkg::sdiar_in_s inSmp, // De-embedded sample
  output logic inField, // Field start
  output logic outTick, // Output period start
  input wire sdiar_pkg::sdiar_out_s outSmp // Sample from router
);
  logic [23:0] cap [16];
  logic [15:0] vld, byp;
  initial
  begin
    inSmp = '0;
    inField = 1'b0;
    outTick = 1'b0;
  end
  task automatic send(input logic [3:0] s, input logic [23:0] d,
    input logic np, input logic er);
    @(posedge ref_clk);
    inSmp <= '{1'b1, s, d, np, er};
    @(posedge ref_clk);
    inSmp.valid <= 1'b0;
    inSmp.data <= ~d;
  endtask
  task automatic field();
    @(posedge ref_clk);
    inField <= 1'b1;
    @(posedge ref_clk);
    inField <= 1'b0;
  endtask
  task automatic tick();
    vld = '0;
    @(posedge ref_clk);
    outTick <= 1'b1;
    @(posedge ref_clk);
    outTick <= 1'b0;
    repeat (18)
    begin
      @(posedge ref_clk);
      if (outSmp.valid === 1'b1)
      begin
        cap[{outSmp.group, outSmp.chan}] = outSmp.data;
        vld[{outSmp.group, outSmp.chan}] = 1'b1;
        byp[{outSmp.group, outSmp.chan}] = outSmp.srcBypass;
      end
    end
  endtask
endmodule
`default_nettype wire

// [verif/test_sdiar_embedded_audio_router.sv]
// Purpose: Self-checking bench for the embedded-audio router
// Assumes: One bus master, clock enable and select held high
// Notes: Tone sign depends on square phase, so magnitude is compared
`timescale 1ns/1ps
`default_nettype none
module test_sdi_embedded_audio_router;
  logic ref_clk, rstn, hwrite, hreadyout, hresp, inField, outTick;
  logic [1:0] htrans, gpo;
  logic [31:0] haddr, hwdata, hrdata;
  logic [3:0] gpiIn;
  logic [2:0] arcPreset;
  sdiar_pkg::sdiar_in_s inSmp;
  sdiar_pkg::sdiar_out_s outSmp;
  int nFail, nTests, cyc;
  sdiar_router DUT (.ref_clk(ref_clk), .rstn(rstn), .ce(1'b1), .hsel(1'b1),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .inSmp(inSmp), .inField(inField),
    .outTick(outTick), .outSmp(outSmp), .gpiIn(gpiIn), .gpo(gpo),
    .arcPreset(arcPreset));
  sdiar_far_end far (.ref_clk(ref_clk), .inSmp(inSmp), .inField(inField),
    .outTick(outTick), .outSmp(outSmp));
  task automatic finishTest();
    $display("Counts: %0d checks, %0d mismatches", nTests, nFail);
    if (nFail == 0 && nTests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    nTests++;
    if (g !== e)
    begin
      nFail++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic busAddr(input logic [7:0] a, input logic w);
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    busAddr(a, 1'b1);
    hwdata <= d;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
  endtask
  task automatic rdc(input string nm, input logic [7:0] a,
    input logic [31:0] e, input logic [31:0] m = 32'hffffffff);
    busAddr(a, 1'b0);
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    chk(nm, e, hrdata & m);
  endtask
  function automatic logic [31:0] mag(input logic [23:0] x);
    return {8'h0, x[23] ? -x : x};
  endfunction
  task automatic testRegs();
    rdc("ctrl", sdiar_pkg::A_CTRL, 32'hf0);
    rdc("srcsel", sdiar_pkg::A_SRCSEL, 32'hfac688);
    for (int j = 0; j < 4; j++)
      rdc("route", sdiar_pkg::A_ROUTE + 8'(4 * j), {8'(2 * j + 9),
        8'(2 * j + 8), 8'(2 * j + 1), 8'(2 * j)});
    wr(8'h80, 32'hffffffff);
    rdc("unmapped", 8'h80, 32'h0);
    wr(sdiar_pkg::A_STATUS, 32'hffffffff);
    rdc("status", sdiar_pkg::A_STATUS, 32'h0);
    $display("testRegs done");
  endtask
  task automatic testStatus();
    far.send(4'h4, 24'h0a0000, 1'b1, 1'b0);
    far.send(4'h0, 24'h0b0000, 1'b0, 1'b1);
    far.field();
    rdc("status", sdiar_pkg::A_STATUS, 32'h40513);
    far.field();
    rdc("stale", sdiar_pkg::A_STATUS, 32'h0, 32'hffff);
    $display("testStatus done");
  endtask
  task automatic testRoute();
    far.send(4'h0, 24'h123456, 1'b0, 1'b0);
    far.field();
    far.send(4'h0, 24'h100000, 1'b0, 1'b0);
    far.tick();
    chk("out0", 32'h100000, {8'h0, far.cap[0]});
    wr(sdiar_pkg::A_GAIN, 32'h40);
    wr(sdiar_pkg::A_VDELAY, 32'h1);
    far.tick();
    chk("gaindly", 32'h091a2b, {8'h0, far.cap[0]});
    wr(sdiar_pkg::A_VDELAY, 32'h0);
    wr(sdiar_pkg::A_BYPASS, 32'h3);
    far.tick();
    chk("manbyp", 32'h1, {31'h0, far.byp[0]});
    chk("mangain", 32'h100000, {8'h0, far.cap[0]});
    wr(sdiar_pkg::A_BYPASS, 32'h0);
    wr(sdiar_pkg::A_CTRL, 32'hf1);
    far.send(4'h0, 24'h200000, 1'b1, 1'b0);
    far.tick();
    chk("autobyp", 32'h1, {31'h0, far.byp[0]});
    chk("autodata", 32'h200000, {8'h0, far.cap[0]});
    wr(sdiar_pkg::A_CTRL, 32'h12);
    far.tick();
    chk("grpen", 32'hf, {16'h0, far.vld});
    chk("mute", 32'h0, {8'h0, far.cap[0]});
    wr(sdiar_pkg::A_CTRL, 32'hf0);
    wr(sdiar_pkg::A_ROUTE, 32'h09080104);
    far.send(4'h4, 24'h300000, 1'b0, 1'b0);
    far.tick();
    chk("nosrc", 32'h0, {8'h0, far.cap[0]});
    $display("testRoute done");
  endtask
  task automatic testTones();
    logic [31:0] e;
    wr(sdiar_pkg::A_TONE, 32'h40302010);
    for (int c = 16; c < 23; c++)
    begin
      wr(sdiar_pkg::A_ROUTE, {24'h090801, 8'(c)});
      far.tick();
      e = c < 20 ? {9'h0, 8'(16 * (c - 15)), 15'h0} : 32'h0;
      e = c == 21 ? {8'h0, sdiar_pkg::AMP_RP155} : e;
      e = c == 22 ? {8'h0, sdiar_pkg::AMP_R68} : e;
      chk("tone", e, mag(far.cap[0]));
    end
    $display("testTones done");
  endtask
  task automatic testGpi();
    wr(sdiar_pkg::A_GPI, 32'h000202b1);
    repeat (2) @(posedge ref_clk);
    chk("gpo", 32'h2, {30'h0, gpo});
    gpiIn <= 4'he;
    repeat (4) @(posedge ref_clk);
    chk("nofire", 32'h0, {29'h0, arcPreset});
    gpiIn <= 4'hf;
    repeat (4) @(posedge ref_clk);
    chk("rise", 32'h3, {29'h0, arcPreset});
    gpiIn <= 4'hd;
    repeat (4) @(posedge ref_clk);
    chk("fall", 32'h5, {29'h0, arcPreset});
    rdc("gpireg", sdiar_pkg::A_GPI, 32'h05d202b1);
    $display("testGpi done");
  endtask
  initial
  begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  // Whole run needs about 400 cycles; the ceiling leaves ample margin
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc > 20000)
    begin
      nFail++;
      finishTest();
    end
  end
  initial
  begin
    {rstn, hwrite, htrans, haddr, hwdata} = '0;
    gpiIn = 4'hf;
    {nFail, nTests, cyc} = '0;
    repeat (4) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    testRegs();
    testStatus();
    testRoute();
    testTones();
    testGpi();
    finishTest();
  end
endmodule
`default_nettype wire
